/* File: msc_pkg.sv */
// constants and register map of the system register bank
// Notes on behaviour
// - port A flags read, write one clears
// - tone/prescale flags read, write one clears
// - counter/serial flags read, write one clears
// - port A mask low blocks, resets zero
// - counter/serial masks low block, reset zero
// - tone/prescale masks low block, reset zero
// - counter value readable, writes ignored
// - control a bit0 clears counter, reads zero
// - control b bit0 second flag, read only
// - timing disable needs test; sleep pulse; enable
// - watchdog value, sleep permit, watchdog clear
// - power-on bits reset only by power-on
// - index nibbles hold index, no reset
// - nibble pointer selects arrays, resets zero
// - display control a, upper bits power-on
// - display control b resets 111, bit0 power-on
package msc_pkg;
   localparam logic [7:0] ADDR_CTL_A = 8'h60;
   localparam logic [7:0] ADDR_CTL_B = 8'h61;
   localparam logic [7:0] ADDR_VAL_L = 8'h62;
   localparam logic [7:0] ADDR_VAL_M = 8'h63;
   localparam logic [7:0] ADDR_VAL_H = 8'h64;
   localparam logic [7:0] ADDR_MASK_PA = 8'h65;
   localparam logic [7:0] ADDR_MASK_TP = 8'h66;
   localparam logic [7:0] ADDR_MASK_CS = 8'h67;
   localparam logic [7:0] ADDR_FLAG_PA = 8'h68;
   localparam logic [7:0] ADDR_FLAG_TP = 8'h69;
   localparam logic [7:0] ADDR_FLAG_CS = 8'h6a;
   localparam logic [7:0] ADDR_SYS_A = 8'h6b;
   localparam logic [7:0] ADDR_SYS_B = 8'h6c;
   localparam logic [7:0] ADDR_PRESC = 8'h6d;
   localparam logic [7:0] ADDR_IX_L = 8'h6e;
   localparam logic [7:0] ADDR_IX_H = 8'h6f;
   localparam logic [7:0] ADDR_NIB_SEL = 8'h70;
   localparam logic [7:0] ADDR_DISP_A = 8'h71;
   localparam logic [7:0] ADDR_DISP_B = 8'h72;
   localparam logic [7:0] ADDR_VLD_CTL = 8'h73;
   localparam logic [7:0] ADDR_VLD_LVL = 8'h74;
   localparam int NUM_REGS = 21;
   localparam logic [3:0] NIB_ZERO = 4'h0;
   localparam logic [3:0] DISP_B_RST = 4'he;
   localparam logic [3:0] SYS_B_POR = 4'h4;
   localparam logic [3:0] DISP_A_POR = 4'h0;
   localparam logic [3:0] DISP_B_POR_BIT = 4'h0;
   localparam logic [3:0] VLD_LVL_MASK = 4'h7;
   localparam logic [3:0] DISP_A_POR_MASK = 4'hc;
   localparam logic [3:0] DISP_B_POR_MASK = 4'h1;
   localparam logic [3:0] SYS_B_POR_MASK = 4'h4;
   localparam int BIT0 = 0;
   localparam int BIT1 = 1;
   localparam int BIT2 = 2;
   localparam int BIT3 = 3;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {WR_IDLE, WR_RESP} msc_wr_e;
endpackage

/* File: msc_flag_nibble.sv */
// four sticky event flags with write-one-to-clear
`timescale 1ns/10ps
module msc_flag_nibble
   import msc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic [3:0] setEvt,
   input wire logic clrStb,
   input wire logic [3:0] clrData,
   output logic [3:0] flags
);
   logic [3:0] flags_q;
   logic [3:0] flags_d;
   // a set in the clear cycle wins so no event is lost
   always_comb begin
      flags_d = (flags_q & ~(clrStb ? clrData : NIB_ZERO)) | setEvt;
   end
   always_ff @(posedge core_clk) begin
      if (rst) begin
         flags_q <= NIB_ZERO;
      end else begin
         flags_q <= flags_d;
      end
   end
   assign flags = flags_q;
   set_wins_a: assert property (@(posedge core_clk) disable iff (rst)
      (setEvt != 4'h0) |=> ((flags_q & $past(setEvt)) == $past(setEvt)))
      else $error("flag event lost");
   clear_a: assert property (@(posedge core_clk) disable iff (rst)
      (clrStb && setEvt == 4'h0) |=> ((flags_q & $past(clrData)) == 4'h0))
      else $error("flag not cleared");
endmodule

/* File: msc_irq_system_regs.sv */
// axi4-lite register bank for counter, interrupt, system and display control
`timescale 1ns/10ps
module msc_irq_system_regs
   import msc_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic porRst,
   input wire logic testMode,
   input wire logic [31:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [31:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [11:0] msCounterValue,
   input wire logic oneSecondFlag,
   input wire logic [3:0] portAIntEvt,
   input wire logic [3:0] tonePrescaleIntEvt,
   input wire logic [3:0] counterSerialIntEvt,
   input wire logic levelDetectDone,
   input wire logic levelDetectResult,
   input wire logic [1:0] watchdogValue,
   output logic [3:0] portAIntPending,
   output logic [3:0] tonePrescaleIntPending,
   output logic [3:0] counterSerialIntPending,
   output logic globalIntEnable,
   output logic msCounterClear,
   output logic [2:0] msControl,
   output logic [2:0] msControlB,
   output logic chipTimingDisable,
   output logic selIntFull,
   output logic sleepRequest,
   output logic sleepPermit,
   output logic watchdogClear,
   output logic prescalerClear,
   output logic [2:0] prescalerSelect,
   output logic [7:0] indexRegister,
   output logic [3:0] indexedNibblePointer,
   output logic [3:0] displayControlA,
   output logic [3:0] displayControlB,
   output logic [1:0] watchdogDisable,
   output logic levelDetectStart,
   output logic [2:0] levelDetectLevel
);
   // word index of a register (address bits 9:2), also used for the read mux
   function automatic logic [7:0] regIdx(input logic [31:0] a);
      regIdx = a[9:2];
   endfunction
   function automatic logic isMapped(input logic [31:0] a);
      isMapped = (a[31:10] == 22'h0) && (a[1:0] == 2'h0) &&
         (a[9:2] >= ADDR_CTL_A) && (a[9:2] <= ADDR_VLD_LVL);
   endfunction

   logic [31:0] awAddr_q, awAddr_d;
   logic [31:0] wData_q, wData_d;
   logic [3:0] wStrb_q, wStrb_d;
   logic awHave_q, awHave_d, wHave_q, wHave_d;
   logic bValid_q, bValid_d;
   logic [1:0] bResp_q, bResp_d;
   logic rValid_q, rValid_d;
   logic [1:0] rResp_q, rResp_d;
   logic [31:0] rData_q, rData_d;
   logic wrFire;
   logic [7:0] wIdx;
   logic [3:0] wNib;

   // write channel capture; address and data may come in either order
   always_comb begin
      awAddr_d = awAddr_q;
      wData_d = wData_q;
      wStrb_d = wStrb_q;
      awHave_d = awHave_q;
      wHave_d = wHave_q;
      bValid_d = bValid_q;
      bResp_d = bResp_q;
      if (s_axi_awvalid && s_axi_awready) begin
         awAddr_d = s_axi_awaddr;
         awHave_d = 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         wData_d = s_axi_wdata;
         wStrb_d = s_axi_wstrb;
         wHave_d = 1'b1;
      end
      if (wrFire) begin
         awHave_d = 1'b0;
         wHave_d = 1'b0;
         bValid_d = 1'b1;
         bResp_d = isMapped(awAddr_q) ? RESP_OKAY : RESP_SLVERR;
      end else if (bValid_q && s_axi_bready) begin
         bValid_d = 1'b0;
      end
   end
   assign s_axi_awready = !awHave_q && !bValid_q;
   assign s_axi_wready = !wHave_q && !bValid_q;
   assign wrFire = awHave_q && wHave_q && !bValid_q;
   assign wIdx = regIdx(awAddr_q);
   // only lane 0 carries the nibble; a write without it changes nothing
   assign wNib = wData_q[3:0];
   always_ff @(posedge core_clk) begin
      if (rst) begin
         awAddr_q <= 32'h0;
         wData_q <= 32'h0;
         wStrb_q <= 4'h0;
         awHave_q <= 1'b0;
         wHave_q <= 1'b0;
         bValid_q <= 1'b0;
         bResp_q <= RESP_OKAY;
      end else begin
         awAddr_q <= awAddr_d;
         wData_q <= wData_d;
         wStrb_q <= wStrb_d;
         awHave_q <= awHave_d;
         wHave_q <= wHave_d;
         bValid_q <= bValid_d;
         bResp_q <= bResp_d;
      end
   end
   assign s_axi_bvalid = bValid_q;
   assign s_axi_bresp = bResp_q;

   function automatic logic hit(input logic [7:0] i, input logic [7:0] r);
      // aliases above the map answer slverr and must not land in a register
      hit = wrFire && wStrb_q[0] && isMapped(awAddr_q) && (i == r);
   endfunction

   // plain control state
   logic [3:0] maskPa_q, maskPa_d, maskTp_q, maskTp_d, maskCs_q, maskCs_d;
   logic [2:0] ctlA_q, ctlA_d, ctlB_q, ctlB_d;
   logic [2:0] sysA_q, sysA_d, presc_q, presc_d;
   logic [3:0] ixL_q, ixL_d, ixH_q, ixH_d, nibSel_q, nibSel_d;
   logic [3:0] dispA_q, dispA_d, dispB_q, dispB_d;
   logic sleepPermit_q, sleepPermit_d;
   logic [1:0] wdDis_q, wdDis_d;
   logic level_detect_busy_q, level_detect_busy_d, vldRes_q, vldRes_d;
   logic [2:0] vldLvl_q, vldLvl_d;
   logic pulseClr_q, pulseClr_d, pulseSleep_q, pulseSleep_d;
   logic pulseWd_q, pulseWd_d, pulsePresc_q, pulsePresc_d;
   logic pulseVld_q, pulseVld_d;

   always_comb begin
      maskPa_d = hit(wIdx, ADDR_MASK_PA) ? wNib : maskPa_q;
      maskTp_d = hit(wIdx, ADDR_MASK_TP) ? wNib : maskTp_q;
      maskCs_d = hit(wIdx, ADDR_MASK_CS) ? wNib : maskCs_q;
      ctlA_d = hit(wIdx, ADDR_CTL_A) ? wNib[3:1] : ctlA_q;
      ctlB_d = hit(wIdx, ADDR_CTL_B) ? wNib[3:1] : ctlB_q;
      sysA_d = hit(wIdx, ADDR_SYS_A) ? {wNib[BIT3], wNib[1:0]} : sysA_q;
      presc_d = hit(wIdx, ADDR_PRESC) ? {wNib[BIT3], wNib[1:0]} : presc_q;
      ixL_d = hit(wIdx, ADDR_IX_L) ? wNib : ixL_q;
      ixH_d = hit(wIdx, ADDR_IX_H) ? wNib : ixH_q;
      nibSel_d = hit(wIdx, ADDR_NIB_SEL) ? wNib : nibSel_q;
      dispA_d = hit(wIdx, ADDR_DISP_A) ? wNib : dispA_q;
      dispB_d = hit(wIdx, ADDR_DISP_B) ? wNib : dispB_q;
      sleepPermit_d = hit(wIdx, ADDR_SYS_B) ? wNib[BIT2] : sleepPermit_q;
      wdDis_d = hit(wIdx, ADDR_VLD_CTL) ? wNib[1:0] : wdDis_q;
      vldLvl_d = hit(wIdx, ADDR_VLD_LVL) ? wNib[2:0] : vldLvl_q;
      pulseClr_d = hit(wIdx, ADDR_CTL_A) && wNib[BIT0];
      pulseSleep_d = hit(wIdx, ADDR_SYS_A) && wNib[BIT2];
      pulseWd_d = hit(wIdx, ADDR_SYS_B) && wNib[BIT3];
      pulsePresc_d = hit(wIdx, ADDR_PRESC) && wNib[BIT2];
      pulseVld_d = hit(wIdx, ADDR_VLD_CTL) && wNib[BIT2] && !level_detect_busy_q;
      // busy from start until the detector reports; result held after
      level_detect_busy_d = level_detect_busy_q;
      vldRes_d = vldRes_q;
      if (pulseVld_d) begin
         level_detect_busy_d = 1'b1;
      end else if (level_detect_busy_q && levelDetectDone) begin
         level_detect_busy_d = 1'b0;
         vldRes_d = levelDetectResult;
      end
   end

   always_ff @(posedge core_clk) begin
      if (rst) begin
         maskPa_q <= NIB_ZERO;
         maskTp_q <= NIB_ZERO;
         maskCs_q <= NIB_ZERO;
         ctlA_q <= 3'h0;
         ctlB_q <= 3'h0;
         sysA_q <= 3'h0;
         presc_q <= 3'h0;
         nibSel_q <= NIB_ZERO;
         dispA_q <= (dispA_q & DISP_A_POR_MASK);
         dispB_q <= DISP_B_RST | (dispB_q & DISP_B_POR_MASK);
         wdDis_q <= 2'h0;
         level_detect_busy_q <= 1'b0;
         vldRes_q <= 1'b0;
         pulseClr_q <= 1'b0;
         pulseSleep_q <= 1'b0;
         pulseWd_q <= 1'b0;
         pulsePresc_q <= 1'b0;
         pulseVld_q <= 1'b0;
      end else begin
         maskPa_q <= maskPa_d;
         maskTp_q <= maskTp_d;
         maskCs_q <= maskCs_d;
         ctlA_q <= ctlA_d;
         ctlB_q <= ctlB_d;
         sysA_q <= sysA_d;
         presc_q <= presc_d;
         nibSel_q <= nibSel_d;
         dispA_q <= dispA_d;
         dispB_q <= dispB_d;
         wdDis_q <= wdDis_d;
         level_detect_busy_q <= level_detect_busy_d;
         vldRes_q <= vldRes_d;
         pulseClr_q <= pulseClr_d;
         pulseSleep_q <= pulseSleep_d;
         pulseWd_q <= pulseWd_d;
         pulsePresc_q <= pulsePresc_d;
         pulseVld_q <= pulseVld_d;
      end
      // power-on bits: system reset keeps them, only power-on loads them
      if (porRst) begin
         sleepPermit_q <= SYS_B_POR[BIT2];
         dispA_q <= DISP_A_POR;
         dispB_q <= DISP_B_RST | DISP_B_POR_BIT;
      end else begin
         sleepPermit_q <= sleepPermit_d;
      end
      // index nibbles have no defined reset value
      ixL_q <= ixL_d;
      ixH_q <= ixH_d;
      vldLvl_q <= vldLvl_d;
   end

   // the three sticky flag groups
   logic [3:0] flagPa, flagTp, flagCs;
   msc_flag_nibble u_flagPa (
      .core_clk(core_clk), .rst(rst), .setEvt(portAIntEvt),
      .clrStb(hit(wIdx, ADDR_FLAG_PA)), .clrData(wNib), .flags(flagPa));
   msc_flag_nibble u_flagTp (
      .core_clk(core_clk), .rst(rst), .setEvt(tonePrescaleIntEvt),
      .clrStb(hit(wIdx, ADDR_FLAG_TP)), .clrData(wNib), .flags(flagTp));
   msc_flag_nibble u_flagCs (
      .core_clk(core_clk), .rst(rst), .setEvt(counterSerialIntEvt),
      .clrStb(hit(wIdx, ADDR_FLAG_CS)), .clrData(wNib), .flags(flagCs));

   // mask bit low blocks the pending request
   assign portAIntPending = flagPa & maskPa_q;
   assign tonePrescaleIntPending = flagTp & maskTp_q;
   assign counterSerialIntPending = flagCs & maskCs_q;

   // read mux; write-only pulse bits read as zero, except level-detect start bit 2, which reads busy
   logic [3:0] rdNib;
   always_comb begin
      case (regIdx(s_axi_araddr))
         ADDR_CTL_A: rdNib = {ctlA_q, 1'b0};
         ADDR_CTL_B: rdNib = {ctlB_q, oneSecondFlag};
         ADDR_VAL_L: rdNib = msCounterValue[3:0];
         ADDR_VAL_M: rdNib = msCounterValue[7:4];
         ADDR_VAL_H: rdNib = msCounterValue[11:8];
         ADDR_MASK_PA: rdNib = maskPa_q;
         ADDR_MASK_TP: rdNib = maskTp_q;
         ADDR_MASK_CS: rdNib = maskCs_q;
         ADDR_FLAG_PA: rdNib = flagPa;
         ADDR_FLAG_TP: rdNib = flagTp;
         ADDR_FLAG_CS: rdNib = flagCs;
         ADDR_SYS_A: rdNib = {sysA_q[2], 1'b0, sysA_q[1:0]};
         ADDR_SYS_B: rdNib = {1'b0, sleepPermit_q, watchdogValue};
         ADDR_PRESC: rdNib = {presc_q[2], 1'b0, presc_q[1:0]};
         ADDR_IX_L: rdNib = ixL_q;
         ADDR_IX_H: rdNib = ixH_q;
         ADDR_NIB_SEL: rdNib = nibSel_q;
         ADDR_DISP_A: rdNib = dispA_q;
         ADDR_DISP_B: rdNib = dispB_q;
         ADDR_VLD_CTL: rdNib = {vldRes_q, level_detect_busy_q, wdDis_q};
         ADDR_VLD_LVL: rdNib = {1'b0, vldLvl_q};
         default: rdNib = NIB_ZERO;
      endcase
      rValid_d = rValid_q;
      rData_d = rData_q;
      rResp_d = rResp_q;
      if (s_axi_arvalid && s_axi_arready) begin
         rValid_d = 1'b1;
         rData_d = {28'h0, (isMapped(s_axi_araddr) ? rdNib : NIB_ZERO)};
         rResp_d = isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
      end else if (rValid_q && s_axi_rready) begin
         rValid_d = 1'b0;
      end
   end
   assign s_axi_arready = !rValid_q;
   always_ff @(posedge core_clk) begin
      if (rst) begin
         rValid_q <= 1'b0;
         rData_q <= 32'h0;
         rResp_q <= RESP_OKAY;
      end else begin
         rValid_q <= rValid_d;
         rData_q <= rData_d;
         rResp_q <= rResp_d;
      end
   end
   assign s_axi_rvalid = rValid_q;
   assign s_axi_rdata = rData_q;
   assign s_axi_rresp = rResp_q;

   // outputs to the peripherals
   assign globalIntEnable = sysA_q[2];
   assign chipTimingDisable = sysA_q[0] && testMode;
   assign selIntFull = sysA_q[1];
   assign msCounterClear = pulseClr_q;
   assign msControl = ctlA_q;
   assign msControlB = ctlB_q;
   assign sleepRequest = pulseSleep_q;
   assign sleepPermit = sleepPermit_q;
   assign watchdogClear = pulseWd_q;
   assign prescalerClear = pulsePresc_q;
   assign prescalerSelect = presc_q;
   assign indexRegister = {ixH_q, ixL_q};
   assign indexedNibblePointer = nibSel_q;
   assign displayControlA = dispA_q;
   assign displayControlB = dispB_q;
   assign watchdogDisable = wdDis_q;
   assign levelDetectStart = pulseVld_q;
   assign levelDetectLevel = vldLvl_q;

   mask_gate_a: assert property (@(posedge core_clk) disable iff (rst)
      (maskPa_q == 4'h0) |-> (portAIntPending == 4'h0))
      else $error("masked port a request visible");
   timing_test_a: assert property (@(posedge core_clk) disable iff (rst)
      !testMode |-> !chipTimingDisable)
      else $error("timing disable without test");
   clear_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      msCounterClear |=> !msCounterClear)
      else $error("counter clear longer than one cycle");
   vld_busy_a: assert property (@(posedge core_clk) disable iff (rst)
      levelDetectStart |-> level_detect_busy_q)
      else $error("start without busy");
   wd_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      (hit(wIdx, ADDR_SYS_B) && wNib[BIT3]) |=> watchdogClear)
      else $error("watchdog clear missing");
   presc_pulse_a: assert property (@(posedge core_clk) disable iff (rst)
      prescalerClear |-> $past(wrFire))
      else $error("prescaler clear without write");
   disp_reset_a: assert property (@(posedge core_clk)
      $past(rst) && !$past(porRst) |-> displayControlB[3:1] == 3'h7)
      else $error("display control b reset wrong");
   ptr_reset_a: assert property (@(posedge core_clk)
      $past(rst) |-> indexedNibblePointer == 4'h0)
      else $error("nibble pointer not reset");
endmodule

/* File: msc_irq_system_regs_test.sv */
// self-checking bench for the system register bank over axi4-lite
`timescale 1ns/10ps
module msc_irq_system_regs_test
   import msc_pkg::*;
;
   `define CHK(got, exp) begin nTests++; if ((got) !== (exp)) begin badCount++; \
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp); end end
   logic core_clk = 1'b0, rst = 1'b1, porRst = 1'b1, testMode = 1'b0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   logic [11:0] msVal = 12'h0;
   logic oneSec = 1'b1, vldDone = 1'b0, vldRes = 1'b0;
   logic [3:0] evtPa = 4'h0, evtTp = 4'h0, evtCs = 4'h0, mask = 4'h0, rnd = 4'h0;
   logic [1:0] wdVal = 2'h2;
   logic [3:0] pendPa, pendTp, pendCs;
   logic gie, ctd;
   logic [2:0] msCtl;
   logic [7:0] ixReg;
   logic msClr, sleepReq, sleepPerm, wdClr, prescClr, selInt, level_detect_start;
   logic [2:0] msCtlB, prescSel, vldLvl;
   logic [3:0] nibPtr, dispA, dispB, wstrb = 4'hf;
   logic [1:0] wdDis;
   logic [21:0] hiBits = 22'h0;
   int pulseCyc = 0;
   logic [33:0] expQ[$];
   int badCount = 0, nTests = 0, cyc = 0;
   integer seed = 32'h2953ed76;

   msc_irq_system_regs dut (.core_clk(core_clk), .rst(rst), .porRst(porRst),
      .testMode(testMode), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
      .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .msCounterValue(msVal), .oneSecondFlag(oneSec), .portAIntEvt(evtPa),
      .tonePrescaleIntEvt(evtTp), .counterSerialIntEvt(evtCs),
      .levelDetectDone(vldDone), .levelDetectResult(vldRes), .watchdogValue(wdVal),
      .portAIntPending(pendPa), .tonePrescaleIntPending(pendTp),
      .counterSerialIntPending(pendCs), .globalIntEnable(gie), .msCounterClear(msClr),
      .msControl(msCtl), .msControlB(msCtlB), .chipTimingDisable(ctd),
      .selIntFull(selInt), .sleepRequest(sleepReq), .sleepPermit(sleepPerm),
      .watchdogClear(wdClr), .prescalerClear(prescClr), .prescalerSelect(prescSel),
      .indexRegister(ixReg), .indexedNibblePointer(nibPtr), .displayControlA(dispA),
      .displayControlB(dispB), .watchdogDisable(wdDis), .levelDetectStart(level_detect_start),
      .levelDetectLevel(vldLvl));

   // free-running clock, 20 ns period
   initial begin
      forever #10 core_clk = ~core_clk;
   end

   // hang guard; a full run needs well under a thousand cycles
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         badCount++;
         closeOut();
      end
   end

   // monitor: every bus answer takes the oldest expectation off the queue
   always @(negedge core_clk) begin
      if (bvalid && bready) cmpNext({bresp, 32'h0});
      if (rvalid && rready) cmpNext({rresp, rdata});
      // every strobe write must give exactly one pulse cycle
      if (!rst) pulseCyc += msClr + sleepReq + wdClr + prescClr + level_detect_start;
   end

   task automatic cmpNext(input logic [33:0] got);
      logic [33:0] e;
      if (expQ.size() == 0) begin
         badCount++;
         $display("CHECK FAILED t=%0t answer with nothing expected", $time);
      end else begin
         e = expQ.pop_front();
         `CHK(got, e)
      end
   endtask

   // write one nibble; aw and w are released independently as each is taken
   task automatic wr(input logic [7:0] off, input logic [3:0] d, input logic [1:0] er);
      logic ta, tw, tb;
      expQ.push_back({er, 32'h0});
      awaddr <= {hiBits, off, 2'b00};
      wdata <= {28'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid && bready;
         @(posedge core_clk);
         if (ta) awvalid <= 1'b0;
         if (tw) wvalid <= 1'b0;
      end while (!tb);
      bready <= 1'b0;
      // one idle edge so a following call never re-drives bready in this step
      @(posedge core_clk);
   endtask

   // read one nibble; rready held until the answer is sampled
   task automatic rd(input logic [7:0] off, input logic [3:0] d, input logic [1:0] er);
      logic ta, tr;
      expQ.push_back({er, 28'h0, d});
      araddr <= {22'h0, off, 2'b00};
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
         @(negedge core_clk);
         ta = arvalid && arready;
         tr = rvalid && rready;
         @(posedge core_clk);
         if (ta) arvalid <= 1'b0;
      end while (!tr);
      rready <= 1'b0;
      @(posedge core_clk);
   endtask

   task automatic doReset(input logic por);
      rst <= 1'b1;
      porRst <= por;
      repeat (6) @(posedge core_clk);
      rst <= 1'b0;
      porRst <= 1'b0;
      @(posedge core_clk);
   endtask

   // direct port checks are taken mid-cycle, away from the edge
   task automatic settle();
      @(negedge core_clk);
   endtask

   function automatic logic [3:0] rstVal(input logic [7:0] off);
      case (off)
         ADDR_CTL_B: rstVal = {3'h0, oneSec};
         ADDR_VAL_L: rstVal = msVal[3:0];
         ADDR_VAL_M: rstVal = msVal[7:4];
         ADDR_VAL_H: rstVal = msVal[11:8];
         ADDR_SYS_B: rstVal = {2'h1, wdVal};
         ADDR_DISP_B: rstVal = DISP_B_RST;
         default: rstVal = NIB_ZERO;
      endcase
   endfunction

   task automatic closeOut();
      $display("comparisons %0d mismatches %0d", nTests, badCount);
      if (badCount == 0 && nTests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   initial begin
      msVal = $random(seed);
      doReset(1'b1);
      // reset values of every register except the unreset index nibbles and level, unmapped place refused
      for (int a = 8'h60; a <= 8'h74; a++) begin
         if (a != 8'h6e && a != 8'h6f && a != 8'h74) begin
            rd(a[7:0], rstVal(a[7:0]), RESP_OKAY);
         end
      end
      rd(8'h75, 4'h0, RESP_SLVERR);
      wr(8'h75, 4'hf, RESP_SLVERR);
      $display("test reset_values done");

      // flags: set by events, masked pending, cleared by writing ones
      mask = $random(seed);
      wr(ADDR_MASK_PA, mask, RESP_OKAY);
      wr(ADDR_MASK_TP, 4'h6, RESP_OKAY);
      wr(ADDR_MASK_CS, 4'h9, RESP_OKAY);
      evtPa <= 4'hf;
      evtTp <= 4'ha;
      evtCs <= 4'h5;
      @(posedge core_clk);
      evtPa <= 4'h0;
      evtTp <= 4'h0;
      evtCs <= 4'h0;
      rd(ADDR_FLAG_PA, 4'hf, RESP_OKAY);
      settle();
      `CHK(pendPa, mask)
      `CHK(pendTp, 4'h2)
      `CHK(pendCs, 4'h1)
      @(posedge core_clk);
      wr(ADDR_FLAG_PA, 4'h5, RESP_OKAY);
      rd(ADDR_FLAG_PA, 4'ha, RESP_OKAY);
      wr(ADDR_FLAG_TP, 4'h2, RESP_OKAY);
      rd(ADDR_FLAG_TP, 4'h8, RESP_OKAY);
      wr(ADDR_FLAG_CS, 4'hf, RESP_OKAY);
      rd(ADDR_FLAG_CS, 4'h0, RESP_OKAY);
      settle();
      `CHK(pendPa, 4'ha & mask)
      `CHK(pendCs, 4'h0)
      @(posedge core_clk);
      $display("test irq_flags done");

      // control registers: pulse bits read zero, counter value not writable
      wr(ADDR_CTL_A, 4'hf, RESP_OKAY);
      rd(ADDR_CTL_A, 4'he, RESP_OKAY);
      wr(ADDR_CTL_B, 4'hf, RESP_OKAY);
      rd(ADDR_CTL_B, {3'h7, oneSec}, RESP_OKAY);
      wr(ADDR_VAL_L, ~msVal[3:0], RESP_OKAY);
      rd(ADDR_VAL_L, msVal[3:0], RESP_OKAY);
      wr(ADDR_SYS_A, 4'hf, RESP_OKAY);
      rd(ADDR_SYS_A, 4'hb, RESP_OKAY);
      settle();
      `CHK(msCtl, 3'h7)
      `CHK(gie, 1'b1)
      `CHK(ctd, 1'b0)
      @(posedge core_clk);
      testMode <= 1'b1;
      settle();
      `CHK(ctd, 1'b1)
      @(posedge core_clk);
      wr(ADDR_SYS_B, 4'h8, RESP_OKAY);
      rd(ADDR_SYS_B, {2'h0, wdVal}, RESP_OKAY);
      wr(ADDR_PRESC, 4'hf, RESP_OKAY);
      rd(ADDR_PRESC, 4'hb, RESP_OKAY);
      rnd = $random(seed);
      wr(ADDR_NIB_SEL, rnd, RESP_OKAY);
      rd(ADDR_NIB_SEL, rnd, RESP_OKAY);
      // lane 0 off, then an alias above the map: neither may land
      wstrb <= 4'he;
      wr(ADDR_NIB_SEL, ~rnd, RESP_OKAY);
      wstrb <= 4'hf;
      hiBits = 22'h1;
      wr(ADDR_NIB_SEL, ~rnd, RESP_SLVERR);
      hiBits = 22'h0;
      rd(ADDR_NIB_SEL, rnd, RESP_OKAY);
      wr(ADDR_IX_L, 4'h3, RESP_OKAY);
      wr(ADDR_IX_H, 4'hc, RESP_OKAY);
      rd(ADDR_IX_H, 4'hc, RESP_OKAY);
      settle();
      `CHK(ixReg, 8'hc3)
      `CHK(msCtlB, 3'h7)
      `CHK(selInt, 1'b1)
      `CHK(prescSel, 3'h7)
      `CHK(nibPtr, rnd)
      @(posedge core_clk);
      $display("test control_regs done");

      // level detector: busy after start, done drops busy and shows result
      wr(ADDR_VLD_CTL, 4'h7, RESP_OKAY);
      rd(ADDR_VLD_CTL, 4'h7, RESP_OKAY);
      vldDone <= 1'b1;
      vldRes <= 1'b1;
      @(posedge core_clk);
      vldDone <= 1'b0;
      rd(ADDR_VLD_CTL, 4'hb, RESP_OKAY);
      wr(ADDR_VLD_LVL, 4'hf, RESP_OKAY);
      rd(ADDR_VLD_LVL, VLD_LVL_MASK, RESP_OKAY);
      settle();
      `CHK(wdDis, 2'h3)
      `CHK(vldLvl, 3'h7)
      @(posedge core_clk);
      $display("test level_detect done");

      // power-on bits survive a plain reset, then follow a power-on reset
      wr(ADDR_DISP_A, 4'hf, RESP_OKAY);
      wr(ADDR_DISP_B, 4'h1, RESP_OKAY);
      rd(ADDR_DISP_B, 4'h1, RESP_OKAY);
      doReset(1'b0);
      rd(ADDR_DISP_A, 4'hc, RESP_OKAY);
      rd(ADDR_DISP_B, 4'hf, RESP_OKAY);
      rd(ADDR_SYS_B, {2'h0, wdVal}, RESP_OKAY);
      settle();
      `CHK(dispA, 4'hc)
      `CHK(dispB, 4'hf)
      `CHK(sleepPerm, 1'b0)
      @(posedge core_clk);
      doReset(1'b1);
      rd(ADDR_DISP_A, 4'h0, RESP_OKAY);
      rd(ADDR_DISP_B, 4'he, RESP_OKAY);
      rd(ADDR_SYS_B, {2'h1, wdVal}, RESP_OKAY);
      settle();
      `CHK(sleepPerm, 1'b1)
      `CHK(dispB, DISP_B_RST)
      `CHK(pulseCyc, 5)
      @(posedge core_clk);
      $display("test power_on_bits done");
      repeat (2) @(posedge core_clk);
      closeOut();
   end
endmodule
